// ---- secp_map.svh ----
`ifndef SECP_MAP_SVH
`define SECP_MAP_SVH

`define SECP_OP_READ       8'h03
`define SECP_OP_WRITE      8'h02
`define SECP_OP_CLR_LATCH  8'h04
`define SECP_OP_SET_LATCH  8'h06
`define SECP_OP_STAT_RD    8'h05
`define SECP_OP_STAT_WR    8'h01

`define SECP_ST_BUSY       0
`define SECP_ST_LATCH      1
`define SECP_ST_BP_LO      2
`define SECP_ST_BP_HI      3
`define SECP_ST_PIN_EN     7

`define SECP_BP_NONE       2'h0
`define SECP_BP_QUARTER    2'h1
`define SECP_BP_HALF       2'h2
`define SECP_BP_ALL        2'h3
`define SECP_QUARTER_BASE  11'h600
`define SECP_HALF_BASE     11'h400
`define SECP_ADDR_TOP      11'h7ff

`define SECP_NV_RESET      3'h0
`define SECP_PIN_RESET     5'h13
`define SECP_ARRAY_BYTES   2048
`define SECP_PAGE_BYTES    16
`define SECP_TWC_NS        5000000
`define SECP_CLK_NS        10

`endif

// ---- secp_pkg.sv ----
package secp_pkg;

    typedef enum logic [2:0] {
        st_cmd,
        st_addr,
        st_read,
        st_wdata,
        st_stat_rd,
        st_stat_wr,
        st_skip
    } secp_state_t;

endpackage

// ---- secp_sync.sv ----
`timescale 1ns/100ps
module secp_sync #(
    parameter int               WIDTH     = 5,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    always_comb begin
        next_stage1   = async_in;
        next_sync_out = stage1;
    end

    // First stage feeds only the second one
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stage1   <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            stage1   <= next_stage1;
            sync_out <= next_sync_out;
        end
    end

endmodule

// ---- secp_eeprom.sv ----
`timescale 1ns/100ps
`include "secp_map.svh"
module secp_eeprom #(
    parameter int PAGE_BYTES   = `SECP_PAGE_BYTES,
    parameter int WRITE_CYCLES = `SECP_TWC_NS / `SECP_CLK_NS
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic hold_n,
    input  wire logic wp_n,
    output logic      so_out,
    output logic      so_oe
);

    localparam int PW = $clog2(PAGE_BYTES);
    localparam int CW = $clog2(WRITE_CYCLES + 1);
    localparam logic [CW-1:0] BUSY_LAST = CW'(WRITE_CYCLES - 1);
    localparam logic [CW-1:0] COMMIT_N  = CW'(PAGE_BYTES);

    if (!(PAGE_BYTES == 16 || PAGE_BYTES == 32)) begin : g_bad_page
        $error("PAGE_BYTES must be 16 or 32");
    end
    // The page is committed one byte per cycle inside the busy window
    if (WRITE_CYCLES < 2 * PAGE_BYTES) begin : g_bad_cycles
        $error("WRITE_CYCLES too small for page commit");
    end

    function automatic logic prot_hit(input logic [10:0] addr, input logic [1:0] bp);
        case (bp)
            `SECP_BP_NONE:    prot_hit = 1'b0;
            `SECP_BP_QUARTER: prot_hit = (addr >= `SECP_QUARTER_BASE);
            `SECP_BP_HALF:    prot_hit = (addr >= `SECP_HALF_BASE);
            default:          prot_hit = 1'b1;
        endcase
    endfunction

    // Pin synchronisers; second stage only is read below
    logic cs_s;
    logic sck_s;
    logic si_s;
    logic hold_s;
    logic wp_s;

    secp_sync #(
        .WIDTH     (5),
        .RESET_VAL (`SECP_PIN_RESET)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in ({cs_n, sck, si, hold_n, wp_n}),
        .sync_out ({cs_s, sck_s, si_s, hold_s, wp_s})
    );

    logic sck_d;
    logic cs_d;
    logic next_sck_d;
    logic next_cs_d;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;

    always_comb begin
        next_sck_d = sck_s;
        next_cs_d  = cs_s;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sck_d <= 1'b0;
            cs_d  <= 1'b1;
        end else begin
            sck_d <= next_sck_d;
            cs_d  <= next_cs_d;
        end
    end

    // Paused link sees no clock edges, so the sequence just freezes
    assign sck_rise = sck_s & ~sck_d & ~cs_s & hold_s;
    assign sck_fall = ~sck_s & sck_d & ~cs_s & hold_s;
    assign cs_rise  = cs_s & ~cs_d;

    logic [7:0] mem [0:`SECP_ARRAY_BYTES-1];
    logic [7:0] page_buf [0:PAGE_BYTES-1];
    logic [PAGE_BYTES-1:0] page_vld;

    // Serial front end state
    secp_pkg::secp_state_t state;
    secp_pkg::secp_state_t next_state;
    logic [3:0]    bit_cnt;
    logic [3:0]    next_bit_cnt;
    logic [7:0]    rx_byte;
    logic [7:0]    next_rx_byte;
    logic [7:0]    opcode;
    logic [7:0]    next_opcode;
    logic [15:0]   addr_sr;
    logic [15:0]   next_addr_sr;
    logic [7:0]    tx_byte;
    logic [7:0]    next_tx_byte;
    logic [10:0]   rd_ptr;
    logic [10:0]   next_rd_ptr;
    logic [10:0]   page_base;
    logic [10:0]   next_page_base;
    logic [PW-1:0] wr_off;
    logic [PW-1:0] next_wr_off;
    logic          got_byte;
    logic          next_got_byte;
    logic          op_done;
    logic          next_op_done;
    logic [2:0]    stat_new;
    logic [2:0]    next_stat_new;
    logic [7:0]    rx_full;
    logic [10:0]   addr_lo;
    logic          pb_we;
    logic          pb_clr;

    // Protection and write-cycle state
    logic          write_latch_flag;
    logic          next_wel;
    logic [2:0]    nv_stat;
    logic [2:0]    next_nv_stat;
    logic          busy;
    logic          next_busy;
    logic [CW-1:0] busy_cnt;
    logic [CW-1:0] next_busy_cnt;
    logic          job_stat;
    logic          next_job_stat;
    logic [1:0]    bp;
    logic          hw_prot;
    logic [7:0]    status_word;
    logic          start_arr;
    logic          start_stat;
    logic          set_latch;
    logic          clr_latch;
    logic [PW-1:0] cidx;
    logic [10:0]   mem_wa;
    logic          mem_we;

    assign bp      = nv_stat[1:0];
    assign hw_prot = ~wp_s & nv_stat[2];
    // Unused bits 6..4 read as zero
    assign status_word = {nv_stat[2], 3'h0, bp, write_latch_flag, busy};

    always_comb begin
        next_state     = state;
        next_bit_cnt   = bit_cnt;
        next_rx_byte   = rx_byte;
        next_opcode    = opcode;
        next_addr_sr   = addr_sr;
        next_tx_byte   = tx_byte;
        next_rd_ptr    = rd_ptr;
        next_page_base = page_base;
        next_wr_off    = wr_off;
        next_got_byte  = got_byte;
        next_op_done   = op_done;
        next_stat_new  = stat_new;
        pb_we          = 1'b0;
        pb_clr         = 1'b0;
        rx_full        = {rx_byte[6:0], si_s};
        addr_lo        = {addr_sr[9:0], si_s};
        if (cs_s) begin
            next_state    = secp_pkg::st_cmd;
            next_bit_cnt  = 4'h0;
            next_got_byte = 1'b0;
            next_op_done  = 1'b0;
        end else if (sck_rise) begin
            next_op_done = 1'b0;
            next_bit_cnt = bit_cnt + 4'h1;
            next_rx_byte = rx_full;
            case (state)
                secp_pkg::st_cmd: begin
                    if (bit_cnt == 4'h7) begin
                        next_bit_cnt = 4'h0;
                        next_opcode  = rx_full;
                        next_op_done = 1'b1;
                        next_state   = secp_pkg::st_skip;
                        case (rx_full)
                            `SECP_OP_READ: begin
                                if (!busy) next_state = secp_pkg::st_addr;
                            end
                            `SECP_OP_WRITE: begin
                                if (!busy) begin
                                    next_state = secp_pkg::st_addr;
                                    pb_clr     = 1'b1;
                                end
                            end
                            `SECP_OP_STAT_RD: begin
                                next_state   = secp_pkg::st_stat_rd;
                                next_tx_byte = status_word;
                            end
                            `SECP_OP_STAT_WR: begin
                                if (!busy) next_state = secp_pkg::st_stat_wr;
                            end
                            default: next_state = secp_pkg::st_skip;
                        endcase
                    end
                end
                secp_pkg::st_addr: begin
                    next_addr_sr = {addr_sr[14:0], si_s};
                    if (bit_cnt == 4'hf) begin
                        next_bit_cnt = 4'h0;
                        if (opcode == `SECP_OP_READ) begin
                            next_state   = secp_pkg::st_read;
                            next_tx_byte = mem[addr_lo];
                            next_rd_ptr  = addr_lo + 11'h1;
                        end else begin
                            next_state     = secp_pkg::st_wdata;
                            next_page_base = addr_lo;
                            next_wr_off    = addr_lo[PW-1:0];
                        end
                    end
                end
                secp_pkg::st_read: begin
                    if (bit_cnt == 4'h7) begin
                        next_bit_cnt = 4'h0;
                        next_tx_byte = mem[rd_ptr];
                        next_rd_ptr  = rd_ptr + 11'h1;
                    end
                end
                secp_pkg::st_stat_rd: begin
                    if (bit_cnt == 4'h7) begin
                        next_bit_cnt = 4'h0;
                        next_tx_byte = status_word;
                    end
                end
                secp_pkg::st_wdata: begin
                    if (bit_cnt == 4'h7) begin
                        next_bit_cnt  = 4'h0;
                        pb_we         = 1'b1;
                        next_wr_off   = wr_off + PW'(1);
                        next_got_byte = 1'b1;
                    end
                end
                secp_pkg::st_stat_wr: begin
                    if (bit_cnt == 4'h7) begin
                        next_bit_cnt  = 4'h0;
                        next_stat_new = {rx_full[7], rx_full[3], rx_full[2]};
                        next_got_byte = 1'b1;
                    end
                end
                default: next_bit_cnt = bit_cnt;
            endcase
        end else if (sck_fall) begin
            if (state == secp_pkg::st_read || state == secp_pkg::st_stat_rd) begin
                next_tx_byte = {tx_byte[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state     <= secp_pkg::st_cmd;
            bit_cnt   <= 4'h0;
            rx_byte   <= 8'h00;
            opcode    <= 8'h00;
            addr_sr   <= 16'h0000;
            tx_byte   <= 8'h00;
            rd_ptr    <= 11'h000;
            page_base <= 11'h000;
            wr_off    <= '0;
            got_byte  <= 1'b0;
            op_done   <= 1'b0;
            stat_new  <= 3'h0;
        end else begin
            state     <= next_state;
            bit_cnt   <= next_bit_cnt;
            rx_byte   <= next_rx_byte;
            opcode    <= next_opcode;
            addr_sr   <= next_addr_sr;
            tx_byte   <= next_tx_byte;
            rd_ptr    <= next_rd_ptr;
            page_base <= next_page_base;
            wr_off    <= next_wr_off;
            got_byte  <= next_got_byte;
            op_done   <= next_op_done;
            stat_new  <= next_stat_new;
        end
    end

    // Page buffer: later bytes on a wrapped offset overwrite earlier ones
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            page_vld <= '0;
        end else if (pb_clr) begin
            page_vld <= '0;
        end else if (pb_we) begin
            page_buf[wr_off] <= rx_full;
            page_vld[wr_off] <= 1'b1;
        end
    end

    // Deselect must land right after a whole byte, with no extra edge
    assign start_arr  = cs_rise && state == secp_pkg::st_wdata && got_byte
                        && bit_cnt == 4'h0 && write_latch_flag && !busy;
    assign start_stat = cs_rise && state == secp_pkg::st_stat_wr && got_byte
                        && bit_cnt == 4'h0 && write_latch_flag && !busy && !hw_prot;
    assign set_latch  = cs_rise && state == secp_pkg::st_skip && op_done
                        && opcode == `SECP_OP_SET_LATCH && !busy;
    assign clr_latch  = cs_rise && state == secp_pkg::st_skip && op_done
                        && opcode == `SECP_OP_CLR_LATCH && !busy;

    always_comb begin
        next_wel      = write_latch_flag;
        next_nv_stat  = nv_stat;
        next_busy     = busy;
        next_busy_cnt = busy_cnt;
        next_job_stat = job_stat;
        if (busy) begin
            // Runs to the end whatever the select pin does
            next_busy_cnt = busy_cnt + CW'(1);
            if (busy_cnt == BUSY_LAST) begin
                next_busy     = 1'b0;
                next_busy_cnt = '0;
                next_wel      = 1'b0;
                if (job_stat) next_nv_stat = stat_new;
            end
        end else if (start_arr || start_stat) begin
            next_busy     = 1'b1;
            next_job_stat = start_stat;
        end else if (set_latch) begin
            next_wel = 1'b1;
        end else if (clr_latch) begin
            next_wel = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            write_latch_flag      <= 1'b0;
            nv_stat  <= `SECP_NV_RESET;
            busy     <= 1'b0;
            busy_cnt <= '0;
            job_stat <= 1'b0;
        end else begin
            write_latch_flag      <= next_wel;
            nv_stat  <= next_nv_stat;
            busy     <= next_busy;
            busy_cnt <= next_busy_cnt;
            job_stat <= next_job_stat;
        end
    end

    // Commit one buffered byte per cycle at the start of the busy window
    assign cidx   = busy_cnt[PW-1:0];
    assign mem_wa = {page_base[10:PW], cidx};
    assign mem_we = busy && !job_stat && busy_cnt < COMMIT_N && page_vld[cidx]
                    && !prot_hit(mem_wa, bp);

    // Array holds data, not control state, so it has no reset
    always_ff @(posedge ref_clk) begin
        if (mem_we) mem[mem_wa] <= page_buf[cidx];
    end

    logic next_so_out;
    logic next_so_oe;

    always_comb begin
        next_so_out = so_out;
        next_so_oe  = !cs_s && hold_s && (state == secp_pkg::st_read
                      || state == secp_pkg::st_stat_rd);
        if (sck_fall && (state == secp_pkg::st_read || state == secp_pkg::st_stat_rd)) begin
            next_so_out = tx_byte[7];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            so_out <= 1'b0;
            so_oe  <= 1'b0;
        end else begin
            so_out <= next_so_out;
            so_oe  <= next_so_oe;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    chk_so_deselect: assert property (cs_s |=> !so_oe)
        else $error("output driven while deselected");
    chk_so_on_fall: assert property ($changed(so_out) |-> $past(sck_fall))
        else $error("output changed without a falling clock");
    chk_hold_freeze: assert property (
        (!cs_s && !hold_s) |=> ($stable(state) && $stable(bit_cnt)))
        else $error("sequence moved while paused");
    chk_busy_latch: assert property ($rose(busy) |-> $past(write_latch_flag))
        else $error("write cycle started without latch");
    chk_busy_span: assert property ($rose(busy) |-> busy [*8])
        else $error("write cycle cut short");
    chk_latch_after: assert property ($fell(busy) |-> !write_latch_flag)
        else $error("latch survived completed write");
    chk_no_array_read: assert property (busy |-> state != secp_pkg::st_read)
        else $error("array read during write cycle");
    chk_quarter_range: assert property (
        (mem_we && bp == `SECP_BP_QUARTER) |-> mem_wa < 11'h600)
        else $error("write into protected quarter");
    chk_hw_protect: assert property (($rose(busy) && job_stat) |-> !$past(hw_prot))
        else $error("status write under pin protection");
    chk_read_wrap: assert property (
        (sck_rise && state == secp_pkg::st_read && bit_cnt == 4'h7 && rd_ptr == `SECP_ADDR_TOP)
        |=> rd_ptr == 11'h000)
        else $error("read pointer did not wrap");
    chk_latch_set: assert property (set_latch |=> write_latch_flag)
        else $error("set-latch did not take");

    cov_array_write: cover property ($rose(busy) && !job_stat);
    cov_status_write: cover property ($rose(busy) && job_stat);
    cov_read_wrap: cover property (sck_rise && state == secp_pkg::st_read && rd_ptr == 11'h000);
    cov_pause: cover property (!cs_s && !hold_s && state != secp_pkg::st_cmd);

endmodule

// ---- secp_host.sv ----
`timescale 1ns/100ps
module secp_host (
    input  wire logic ref_clk,
    input  wire logic so_out,
    input  wire logic so_oe,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      hold_n
);
    initial begin
        cs_n   = 1'b1;
        sck    = 1'b0;
        si     = 1'b0;
        hold_n = 1'b1;
    end

    task automatic sel();
        @(posedge ref_clk);
        cs_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask

    // Released data line flips so a stale bit is never mistaken for data
    task automatic desel();
        @(posedge ref_clk);
        cs_n <= 1'b1;
        si   <= ~si;
        repeat (20) @(posedge ref_clk);
    endtask

    // Sck only moves inside a frame; 80 ns high and low
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            si <= tx[i];
            repeat (8) @(posedge ref_clk);
            sck <= 1'b1;
            rx  = {rx[6:0], so_oe ? so_out : 1'bz};
            repeat (8) @(posedge ref_clk);
            sck <= 1'b0;
        end
    endtask

    task automatic hold(input logic lvl);
        @(posedge ref_clk);
        hold_n <= lvl;
        repeat (8) @(posedge ref_clk);
    endtask
endmodule

// ---- tb_secp_eeprom.sv ----
`timescale 1ns/100ps
`include "secp_map.svh"
module tb_secp_eeprom;
    localparam int WC = 1000;

    logic       ref_clk = 1'b0;
    logic       rst_n   = 1'b0;
    logic       wp_n    = 1'b1;
    logic       cs_n;
    logic       sck;
    logic       si;
    logic       hold_n;
    logic       so_out;
    logic       so_oe;
    logic [7:0] rx;
    int         n_fail          = 0;
    int         samples_checked = 0;

    always #5 ref_clk = ~ref_clk;

    secp_host i_host (
        .ref_clk (ref_clk),
        .so_out  (so_out),
        .so_oe   (so_oe),
        .cs_n    (cs_n),
        .sck     (sck),
        .si      (si),
        .hold_n  (hold_n)
    );

    secp_eeprom #(.PAGE_BYTES(16), .WRITE_CYCLES(WC)) i_dut (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .cs_n    (cs_n),
        .sck     (sck),
        .si      (si),
        .hold_n  (hold_n),
        .wp_n    (wp_n),
        .so_out  (so_out),
        .so_oe   (so_oe)
    );

    task automatic report_and_stop();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp=%h got=%h", nm, exp, got);
        end
    endtask

    task automatic cmd(input logic [7:0] op);
        i_host.sel();
        i_host.xfer(op, 8, rx);
        i_host.desel();
    endtask

    task automatic stat(input logic [7:0] exp);
        i_host.sel();
        i_host.xfer(`SECP_OP_STAT_RD, 8, rx);
        i_host.xfer(8'h00, 8, rx);
        i_host.desel();
        chk("status", rx, exp);
    endtask

    task automatic stw(input logic [7:0] v);
        i_host.sel();
        i_host.xfer(`SECP_OP_STAT_WR, 8, rx);
        i_host.xfer(v, 8, rx);
        i_host.desel();
    endtask

    task automatic head(input logic [7:0] op, input logic [15:0] a);
        i_host.sel();
        i_host.xfer(op, 8, rx);
        i_host.xfer(a[15:8], 8, rx);
        i_host.xfer(a[7:0], 8, rx);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d[$], input int extra);
        head(`SECP_OP_WRITE, a);
        foreach (d[i]) i_host.xfer(d[i], 8, rx);
        if (extra > 0) i_host.xfer(8'ha5, extra, rx);
        i_host.desel();
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp[$]);
        head(`SECP_OP_READ, a);
        foreach (exp[i]) begin
            i_host.xfer(8'h00, 8, rx);
            chk("read", rx, exp[i]);
        end
        i_host.desel();
    endtask

    task automatic t_latch();
        stat(8'h00);
        chk("oe idle", {7'h0, so_oe}, 8'h00);
        cmd(`SECP_OP_SET_LATCH);
        stat(8'h02);
        cmd(`SECP_OP_CLR_LATCH);
        stat(8'h00);
        // Latch opcode run straight into a write must not arm anything
        i_host.sel();
        i_host.xfer(`SECP_OP_SET_LATCH, 8, rx);
        i_host.xfer(`SECP_OP_WRITE, 8, rx);
        i_host.desel();
        stat(8'h00);
    endtask

    task automatic t_page();
        cmd(`SECP_OP_SET_LATCH);
        wr(16'hf80e, '{8'ha0, 8'ha1, 8'ha2}, 0);
        stat(8'h03);
        head(`SECP_OP_READ, 16'h000e);
        i_host.xfer(8'h00, 8, rx);
        i_host.desel();
        chk("busy read", rx, 8'hzz);
        repeat (WC) @(posedge ref_clk);
        stat(8'h00);
        rd(16'h000e, '{8'ha0, 8'ha1});
        rd(16'h0000, '{8'ha2});
    endtask

    task automatic t_wrap();
        cmd(`SECP_OP_SET_LATCH);
        wr(16'h07ff, '{8'hb0, 8'hb1}, 0);
        // Arrives while the cycle above still runs, so it must be dropped
        wr(16'h0000, '{8'h77}, 0);
        repeat (WC) @(posedge ref_clk);
        rd(16'h07f0, '{8'hb1});
        head(`SECP_OP_READ, 16'hffff);
        i_host.xfer(8'h00, 8, rx);
        chk("top byte", rx, 8'hb0);
        i_host.hold(1'b0);
        repeat (16) @(posedge ref_clk);
        chk("oe paused", {7'h0, so_oe}, 8'h00);
        i_host.hold(1'b1);
        i_host.xfer(8'h00, 8, rx);
        chk("wrapped byte", rx, 8'ha2);
        i_host.desel();
    endtask

    task automatic t_abort();
        cmd(`SECP_OP_SET_LATCH);
        wr(16'h0000, '{8'h55}, 5);
        stat(8'h02);
        rd(16'h0000, '{8'ha2});
        cmd(`SECP_OP_CLR_LATCH);
        wr(16'h0000, '{8'h55}, 0);
        stat(8'h00);
        rd(16'h0000, '{8'ha2});
    endtask

    task automatic t_protect();
        cmd(`SECP_OP_SET_LATCH);
        stw(8'hf4);
        repeat (WC) @(posedge ref_clk);
        stat(8'h84);
        cmd(`SECP_OP_SET_LATCH);
        wr(16'h07ff, '{8'h11}, 0);
        repeat (WC) @(posedge ref_clk);
        rd(16'h07ff, '{8'hb0});
        cmd(`SECP_OP_SET_LATCH);
        wr(16'h05ff, '{8'h22}, 0);
        repeat (WC) @(posedge ref_clk);
        rd(16'h05ff, '{8'h22});
        @(posedge ref_clk) wp_n <= 1'b0;
        cmd(`SECP_OP_SET_LATCH);
        stw(8'h00);
        stat(8'h86);
        @(posedge ref_clk) wp_n <= 1'b1;
        stw(8'h00);
        repeat (WC) @(posedge ref_clk);
        stat(8'h00);
    endtask

    // Half and full protect ranges, on bytes whose contents are known
    task automatic t_ranges();
        cmd(`SECP_OP_SET_LATCH);
        stw(8'h08);
        repeat (WC) @(posedge ref_clk);
        stat(8'h08);
        cmd(`SECP_OP_SET_LATCH);
        wr(16'h05ff, '{8'h44}, 0);
        repeat (WC) @(posedge ref_clk);
        rd(16'h05ff, '{8'h22});
        cmd(`SECP_OP_SET_LATCH);
        wr(16'h000f, '{8'h5a}, 0);
        repeat (WC) @(posedge ref_clk);
        rd(16'h000f, '{8'h5a});
        cmd(`SECP_OP_SET_LATCH);
        stw(8'h0c);
        repeat (WC) @(posedge ref_clk);
        stat(8'h0c);
        cmd(`SECP_OP_SET_LATCH);
        wr(16'h000f, '{8'h66}, 0);
        repeat (WC) @(posedge ref_clk);
        rd(16'h000f, '{8'h5a});
    endtask

    // Whole run is near 30k cycles; the 80k-cycle limit flags a hang
    initial begin
        #800000;
        n_fail++;
        report_and_stop();
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_latch();
        t_page();
        t_wrap();
        t_abort();
        t_protect();
        t_ranges();
        report_and_stop();
    end
endmodule
